// File: verilog/vsrc_pkg.sv
// constants and types for the vector prefix decoder and wide register file
package vsrc_pkg;
  localparam int          VSRC_VEC_W     = 256;
  localparam int          VSRC_HALF_W    = 128;
  localparam int          VSRC_NREG      = 16;
  localparam int          VSRC_IDX_W     = 4;
  localparam int          VSRC_LEG_IDX_W = 3;
  localparam logic [7:0]  VSRC_BYTE_NONE = 8'h00;
  localparam logic [7:0]  VSRC_BYTE_66   = 8'h66;
  localparam logic [7:0]  VSRC_BYTE_F2   = 8'hF2;
  localparam logic [7:0]  VSRC_BYTE_F3   = 8'hF3;
  // long form first payload byte: inverted R, X, B, then map select
  localparam int          VSRC_B1_NR     = 7;
  localparam int          VSRC_B1_NX     = 6;
  localparam int          VSRC_B1_NB     = 5;
  localparam int          VSRC_MAP_HI    = 4;
  // last payload byte: W (long) or inverted R (short), ~vvvv, L, pp
  localparam int          VSRC_B2_TOP    = 7;
  localparam int          VSRC_VVVV_HI   = 6;
  localparam int          VSRC_VVVV_LO   = 3;
  localparam int          VSRC_B2_L      = 2;
  localparam int          VSRC_PP_HI     = 1;
  localparam int          VSRC_IMM_HI    = 7;
  localparam int          VSRC_IMM_LO    = 4;
  localparam logic [4:0]  VSRC_MAP_0F    = 5'h01;
  localparam logic [4:0]  VSRC_MAP_0F38  = 5'h02;
  localparam logic [4:0]  VSRC_MAP_0F3A  = 5'h03;
  localparam logic [1:0]  VSRC_PP_NONE   = 2'h0;
  localparam logic [1:0]  VSRC_PP_66     = 2'h1;
  localparam logic [1:0]  VSRC_PP_F3     = 2'h2;
  localparam logic [1:0]  VSRC_PP_F2     = 2'h3;
  typedef enum logic [1:0] {
    VSRC_ESC_NONE = 2'b00,
    VSRC_ESC_0F   = 2'b01,
    VSRC_ESC_0F38 = 2'b10,
    VSRC_ESC_0F3A = 2'b11
  } vsrc_esc_type;
endpackage

// File: verilog/vsrc_top.sv
// vector prefix field decoder and wide vector register file write control
`timescale 1ns/1ps
// What this block does
// - sixteen 256-bit registers; eight addressable outside 64-bit mode.
// - narrow register name is the low 128 bits of the wide one.
// - unprefixed writes leave bits 255:128 untouched.
// - prefixed 128-bit length writes clear bits 255:128.
// - non-destructive source register number comes from the prefix field.
// - four-operand forms take third source from immediate bits 7:4.
// - register extension and width bits come from prefix fields.
// - prefix pp field stands for legacy 66H, F2H or F3H byte.
// - prefix map field stands for escape 0FH, 0F38H or 0F3AH.
// - prefix length bit picks 128-bit or 256-bit operation.
// - prefix refused on instructions using multimedia or x87 registers.
// - most prefixed memory operations need no 16 or 32 byte alignment.
module vsrc_top (
  input  wire logic                              CLK,            // core clock
  input  wire logic                              RST,            // sync reset
  input  wire logic                              MODE64,         // 64-bit mode
  input  wire logic                              DEC_VALID,      // decode req
  input  wire logic                              DEC_HAS_PFX,    // prefixed
  input  wire logic                              DEC_PFX_LONG,   // 3-byte form
  input  wire logic [7:0]                        DEC_PFX_B1,     // long byte 1
  input  wire logic [7:0]                        DEC_PFX_B2,     // last byte
  input  wire logic [7:0]                        DEC_IMM,        // immediate
  input  wire logic                              DEC_FOUR_OP,    // 4-operand
  input  wire logic                              DEC_PFX_OK,     // op allows
  input  wire logic                              DEC_MM_X87,     // mm/x87 regs
  input  wire logic                              DEC_MEM_OP,     // mem operand
  input  wire logic                              DEC_ALIGNED_OP, // must align
  output logic                                   OUT_VALID,      // result
  output logic [vsrc_pkg::VSRC_IDX_W-1:0]        OUT_SRC_ND,     // nd source
  output logic [vsrc_pkg::VSRC_IDX_W-1:0]        OUT_SRC_THIRD,  // 3rd source
  output logic                                   OUT_EXT_R,      // reg ext R
  output logic                                   OUT_EXT_X,      // index ext
  output logic                                   OUT_EXT_B,      // base ext
  output logic                                   OUT_WIDE_OP,    // W bit
  output logic [7:0]                             OUT_SIMD_PFX,   // implied
  output vsrc_pkg::vsrc_esc_type                 OUT_ESC,        // escape
  output logic                                   OUT_VL256,      // 256 wide
  output logic                                   OUT_ALIGN_REQ,  // align trap
  output logic                                   OUT_INVALID_OP, // #UD
  input  wire logic                              WR_EN,          // write
  input  wire logic [vsrc_pkg::VSRC_IDX_W-1:0]   WR_IDX,         // dest reg
  input  wire logic [vsrc_pkg::VSRC_VEC_W-1:0]   WR_DATA,        // result
  input  wire logic                              WR_PREFIXED,    // prefixed
  input  wire logic                              WR_VL256,       // 256 wide
  input  wire logic [vsrc_pkg::VSRC_IDX_W-1:0]   RD_IDX,         // read reg
  output logic [vsrc_pkg::VSRC_VEC_W-1:0]        RD_WIDE,        // wide view
  output logic [vsrc_pkg::VSRC_HALF_W-1:0]       RD_NARROW       // low view
);
  import vsrc_pkg::*;
  default clocking core_edge @(posedge CLK);
  endclocking
  default disable iff (RST);
  localparam int HI = VSRC_VEC_W - 1;
  localparam int LH = VSRC_HALF_W - 1;
  // decode group
  logic                  valid_reg, valid_next;
  logic [VSRC_IDX_W-1:0] nd_reg, nd_next, third_reg, third_next;
  logic                  r_reg, r_next, x_reg, x_next, b_reg, b_next;
  logic                  w_reg, w_next, vl_reg, vl_next;
  logic                  algn_reg, algn_next, ud_reg, ud_next;
  logic [7:0]            sp_reg, sp_next;
  vsrc_esc_type          esc_reg, esc_next;
  logic [4:0]            map;
  logic [1:0]            pp;
  always_comb begin
    map        = DEC_PFX_LONG ? DEC_PFX_B1[VSRC_MAP_HI:0] : VSRC_MAP_0F;
    pp         = DEC_PFX_B2[VSRC_PP_HI:0];
    valid_next = DEC_VALID;
    nd_next    = nd_reg;
    third_next = third_reg;
    r_next     = r_reg;
    x_next     = x_reg;
    b_next     = b_reg;
    w_next     = w_reg;
    vl_next    = vl_reg;
    sp_next    = sp_reg;
    esc_next   = esc_reg;
    algn_next  = algn_reg;
    ud_next    = ud_reg;
    if (DEC_VALID) begin
      nd_next    = '0;
      third_next = '0;
      r_next     = 1'b0;
      x_next     = 1'b0;
      b_next     = 1'b0;
      w_next     = 1'b0;
      vl_next    = 1'b0;
      sp_next    = VSRC_BYTE_NONE;
      esc_next   = VSRC_ESC_NONE;
      ud_next    = 1'b0;
      algn_next  = DEC_MEM_OP; // legacy forms keep their alignment check
      if (DEC_HAS_PFX) begin
        nd_next = ~DEC_PFX_B2[VSRC_VVVV_HI:VSRC_VVVV_LO];
        if (!MODE64) begin
          nd_next[VSRC_IDX_W-1] = 1'b0;
        end
        if (DEC_FOUR_OP) begin
          third_next = DEC_IMM[VSRC_IMM_HI:VSRC_IMM_LO];
          if (!MODE64) begin
            third_next[VSRC_IDX_W-1] = 1'b0;
          end
        end
        if (MODE64) begin
          if (DEC_PFX_LONG) begin
            r_next = ~DEC_PFX_B1[VSRC_B1_NR];
            x_next = ~DEC_PFX_B1[VSRC_B1_NX];
            b_next = ~DEC_PFX_B1[VSRC_B1_NB];
          end else begin
            r_next = ~DEC_PFX_B2[VSRC_B2_TOP];
          end
        end
        w_next  = DEC_PFX_LONG & DEC_PFX_B2[VSRC_B2_TOP];
        vl_next = DEC_PFX_B2[VSRC_B2_L];
        case (pp)
          VSRC_PP_66: sp_next = VSRC_BYTE_66;
          VSRC_PP_F3: sp_next = VSRC_BYTE_F3;
          VSRC_PP_F2: sp_next = VSRC_BYTE_F2;
          default:    sp_next = VSRC_BYTE_NONE;
        endcase
        case (map)
          VSRC_MAP_0F:   esc_next = VSRC_ESC_0F;
          VSRC_MAP_0F38: esc_next = VSRC_ESC_0F38;
          VSRC_MAP_0F3A: esc_next = VSRC_ESC_0F3A;
          default:       esc_next = VSRC_ESC_NONE;
        endcase
        algn_next = DEC_MEM_OP & DEC_ALIGNED_OP;
        ud_next = !DEC_PFX_OK || DEC_MM_X87 || (esc_next == VSRC_ESC_NONE);
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      valid_reg <= 1'b0;
      nd_reg    <= '0;
      third_reg <= '0;
      r_reg     <= 1'b0;
      x_reg     <= 1'b0;
      b_reg     <= 1'b0;
      w_reg     <= 1'b0;
      vl_reg    <= 1'b0;
      sp_reg    <= VSRC_BYTE_NONE;
      esc_reg   <= VSRC_ESC_NONE;
      algn_reg  <= 1'b0;
      ud_reg    <= 1'b0;
    end else begin
      valid_reg <= valid_next;
      nd_reg    <= nd_next;
      third_reg <= third_next;
      r_reg     <= r_next;
      x_reg     <= x_next;
      b_reg     <= b_next;
      w_reg     <= w_next;
      vl_reg    <= vl_next;
      sp_reg    <= sp_next;
      esc_reg   <= esc_next;
      algn_reg  <= algn_next;
      ud_reg    <= ud_next;
    end
  end
  assign OUT_VALID      = valid_reg;
  assign OUT_SRC_ND     = nd_reg;
  assign OUT_SRC_THIRD  = third_reg;
  assign OUT_EXT_R      = r_reg;
  assign OUT_EXT_X      = x_reg;
  assign OUT_EXT_B      = b_reg;
  assign OUT_WIDE_OP    = w_reg;
  assign OUT_SIMD_PFX   = sp_reg;
  assign OUT_ESC        = esc_reg;
  assign OUT_VL256      = vl_reg;
  assign OUT_ALIGN_REQ  = algn_reg;
  assign OUT_INVALID_OP = ud_reg;

  // register file group: one array, the narrow name is its low half
  logic [VSRC_VEC_W-1:0] regs_reg [VSRC_NREG];
  logic [VSRC_VEC_W-1:0] regs_next [VSRC_NREG];
  logic [VSRC_VEC_W-1:0] rd_reg, rd_next;
  logic [VSRC_IDX_W-1:0] widx, ridx;

  always_comb begin
    widx = WR_IDX;
    ridx = RD_IDX;
    if (!MODE64) begin
      widx[VSRC_IDX_W-1] = 1'b0;
      ridx[VSRC_IDX_W-1] = 1'b0;
    end
    regs_next = regs_reg;
    rd_next   = regs_reg[ridx];
    if (WR_EN) begin
      regs_next[widx][LH:0] = WR_DATA[LH:0];
      if (WR_PREFIXED) begin
        regs_next[widx][HI:VSRC_HALF_W] =
          WR_VL256 ? WR_DATA[HI:VSRC_HALF_W] : '0;
      end // unprefixed: upper half held
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      regs_reg <= '{default: '0};
      rd_reg   <= '0;
    end else begin
      regs_reg <= regs_next;
      rd_reg   <= rd_next;
    end
  end

  assign RD_WIDE   = rd_reg;
  assign RD_NARROW = rd_reg[LH:0];

  // helper state read only by the checks below
  logic [VSRC_IDX_W-1:0] c_idx;
  logic [VSRC_VEC_W-1:0] c_old, c_dat;
  logic [7:0]            c_b1, c_b2, c_imm;
  always_ff @(posedge CLK) begin
    c_idx <= widx;
    c_old <= regs_reg[widx];
    c_dat <= WR_DATA;
    c_b1  <= DEC_PFX_B1;
    c_b2  <= DEC_PFX_B2;
    c_imm <= DEC_IMM;
  end
  property p_idx8;
    WR_EN && !MODE64 |=> c_idx[VSRC_IDX_W-1] == 1'b0;
  endproperty
  a_idx8: assert property (p_idx8)
    else $error("register index above seven outside 64-bit mode");
  property p_low;
    WR_EN |=> regs_reg[c_idx][LH:0] == c_dat[LH:0] ##1
      (RD_NARROW == RD_WIDE[LH:0]);
  endproperty
  a_low: assert property (p_low)
    else $error("low half not written or narrow view differs");
  property p_keep_hi;
    WR_EN && !WR_PREFIXED |=>
      regs_reg[c_idx][HI:VSRC_HALF_W] == c_old[HI:VSRC_HALF_W];
  endproperty
  a_keep_hi: assert property (p_keep_hi)
    else $error("unprefixed write changed upper half");
  property p_zero_hi;
    WR_EN && WR_PREFIXED && !WR_VL256 |=>
      regs_reg[c_idx][HI:VSRC_HALF_W] == '0;
  endproperty
  a_zero_hi: assert property (p_zero_hi)
    else $error("128-bit prefixed write left upper half");
  property p_full;
    WR_EN && WR_PREFIXED && WR_VL256 |=> regs_reg[c_idx] == c_dat;
  endproperty
  a_full: assert property (p_full)
    else $error("256-bit write not stored whole");
  property p_nd;
    DEC_VALID && DEC_HAS_PFX && MODE64 |=>
      OUT_SRC_ND == ~c_b2[VSRC_VVVV_HI:VSRC_VVVV_LO] &&
      OUT_VL256 == c_b2[VSRC_B2_L];
  endproperty
  a_nd: assert property (p_nd)
    else $error("non-destructive source or length wrong");
  property p_third;
    DEC_VALID && DEC_HAS_PFX && DEC_FOUR_OP && MODE64 |=>
      OUT_SRC_THIRD == c_imm[VSRC_IMM_HI:VSRC_IMM_LO];
  endproperty
  a_third: assert property (p_third)
    else $error("third source not from immediate top bits");
  property p_ext;
    DEC_VALID && DEC_HAS_PFX && DEC_PFX_LONG && MODE64 |=>
      OUT_EXT_R == !c_b1[VSRC_B1_NR] && OUT_EXT_B == !c_b1[VSRC_B1_NB] &&
      OUT_WIDE_OP == c_b2[VSRC_B2_TOP];
  endproperty
  a_ext: assert property (p_ext)
    else $error("extension bits wrong");
  property p_pp;
    DEC_VALID && DEC_HAS_PFX && DEC_PFX_B2[VSRC_PP_HI:0] == VSRC_PP_F2
      |=> OUT_SIMD_PFX == VSRC_BYTE_F2;
  endproperty
  a_pp: assert property (p_pp)
    else $error("implied prefix byte wrong");
  property p_esc;
    DEC_VALID && DEC_HAS_PFX && !DEC_PFX_LONG |=> OUT_ESC == VSRC_ESC_0F;
  endproperty
  a_esc: assert property (p_esc)
    else $error("short form escape not 0F");
  property p_mm;
    DEC_VALID && DEC_HAS_PFX && (DEC_MM_X87 || !DEC_PFX_OK) |=>
      OUT_VALID && OUT_INVALID_OP;
  endproperty
  a_mm: assert property (p_mm)
    else $error("refused prefix not flagged invalid");
  property p_align;
    DEC_VALID && DEC_HAS_PFX && !DEC_ALIGNED_OP |=> !OUT_ALIGN_REQ;
  endproperty
  a_align: assert property (p_align)
    else $error("alignment demanded of relaxed prefixed op");
endmodule // vsrc_top

// File: verif/vsrc_pipe_model.sv
// pipeline model that issues random decode requests to the prefix decoder
`timescale 1ns/1ps
module vsrc_pipe_model (
  input  wire logic       clk,        // core clock
  input  wire logic       rst,        // sync reset
  input  wire logic       en,         // issue enable
  output logic            dec_valid,  // request
  output logic            has_pfx,    // prefixed
  output logic            pfx_long,   // three-byte form
  output logic [7:0]      pfx_b1,     // long form byte
  output logic [7:0]      pfx_b2,     // last byte
  output logic [7:0]      imm,        // immediate
  output logic            four_op,    // four operands
  output logic            pfx_ok,     // prefix allowed
  output logic            mm_x87,     // legacy registers
  output logic            mem_op,     // memory operand
  output logic            aligned_op  // needs alignment
);
  int          seed = 25010;
  logic [31:0] r;
  // outputs have this process as their only driver; unknown only under reset
  always @(posedge clk) begin
    r = $random(seed);
    // gaps and back-to-back requests
    dec_valid  <= en && !rst && (r[0] || r[1]);
    has_pfx    <= r[2] || r[3];
    pfx_long   <= r[4];
    // map field limited to 0..3 so that every escape code and a bad one occur
    pfx_b1     <= {r[7:5], 3'h0, r[9:8]};
    pfx_b2     <= r[17:10];
    imm        <= r[25:18];
    four_op    <= r[26];
    pfx_ok     <= r[27] || r[28];
    mm_x87     <= r[29] && r[30];
    mem_op     <= r[31];
    aligned_op <= r[5] ^ r[12];
  end
endmodule // vsrc_pipe_model

// File: verif/vsrc_top_bench.sv
// self-checking bench for the prefix decoder and wide register file
`timescale 1ns/1ps
module vsrc_top_bench;
  import vsrc_pkg::*;
  logic         CLK, RST, MODE64, EN, DEC_VALID, DEC_HAS_PFX, DEC_PFX_LONG;
  logic         DEC_FOUR_OP, DEC_PFX_OK, DEC_MM_X87, DEC_MEM_OP;
  logic         DEC_ALIGNED_OP, OUT_VALID, OUT_EXT_R, OUT_EXT_X, OUT_EXT_B;
  logic         OUT_WIDE_OP, OUT_VL256, OUT_ALIGN_REQ, OUT_INVALID_OP;
  logic         WR_EN, WR_PREFIXED, WR_VL256, e_v, e_on, e_inv, e_vl;
  logic         e_al, e_4op;
  logic [7:0]   DEC_PFX_B1, DEC_PFX_B2, DEC_IMM, OUT_SIMD_PFX, e_pfx;
  logic [3:0]   OUT_SRC_ND, OUT_SRC_THIRD, WR_IDX, RD_IDX, e_nd, e_th, e_x4;
  logic [4:0]   m;
  logic [1:0]   e_esc;
  logic [31:0]  r;
  logic [127:0] RD_NARROW, hi;
  logic [255:0] WR_DATA, RD_WIDE, e_rd, d;
  logic [255:0] mdl [16];
  logic [7:0]   pp_tab [4] = '{8'h00, 8'h66, 8'hF3, 8'hF2};
  vsrc_esc_type OUT_ESC;
  int           seed = 25010;
  int           n_mismatch = 0;
  int           check_count = 0;
  int           cyc = 0;

  vsrc_top u_vsrc_top (.CLK(CLK), .RST(RST), .MODE64(MODE64),
    .DEC_VALID(DEC_VALID), .DEC_HAS_PFX(DEC_HAS_PFX),
    .DEC_PFX_LONG(DEC_PFX_LONG), .DEC_PFX_B1(DEC_PFX_B1),
    .DEC_PFX_B2(DEC_PFX_B2), .DEC_IMM(DEC_IMM), .DEC_FOUR_OP(DEC_FOUR_OP),
    .DEC_PFX_OK(DEC_PFX_OK), .DEC_MM_X87(DEC_MM_X87),
    .DEC_MEM_OP(DEC_MEM_OP), .DEC_ALIGNED_OP(DEC_ALIGNED_OP),
    .OUT_VALID(OUT_VALID), .OUT_SRC_ND(OUT_SRC_ND),
    .OUT_SRC_THIRD(OUT_SRC_THIRD), .OUT_EXT_R(OUT_EXT_R),
    .OUT_EXT_X(OUT_EXT_X), .OUT_EXT_B(OUT_EXT_B), .OUT_WIDE_OP(OUT_WIDE_OP),
    .OUT_SIMD_PFX(OUT_SIMD_PFX), .OUT_ESC(OUT_ESC), .OUT_VL256(OUT_VL256),
    .OUT_ALIGN_REQ(OUT_ALIGN_REQ), .OUT_INVALID_OP(OUT_INVALID_OP),
    .WR_EN(WR_EN), .WR_IDX(WR_IDX), .WR_DATA(WR_DATA),
    .WR_PREFIXED(WR_PREFIXED), .WR_VL256(WR_VL256), .RD_IDX(RD_IDX),
    .RD_WIDE(RD_WIDE), .RD_NARROW(RD_NARROW));

  vsrc_pipe_model u_vsrc_pipe_model (.clk(CLK), .rst(RST), .en(EN),
    .dec_valid(DEC_VALID), .has_pfx(DEC_HAS_PFX), .pfx_long(DEC_PFX_LONG),
    .pfx_b1(DEC_PFX_B1), .pfx_b2(DEC_PFX_B2), .imm(DEC_IMM),
    .four_op(DEC_FOUR_OP), .pfx_ok(DEC_PFX_OK), .mm_x87(DEC_MM_X87),
    .mem_op(DEC_MEM_OP), .aligned_op(DEC_ALIGNED_OP));

  function automatic logic [3:0] ix(input logic [3:0] i);
    return {i[3] & MODE64, i[2:0]};
  endfunction

  task automatic check(input logic [255:0] got, input logic [255:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // reference model: expectations from inputs sampled at this edge
  always @(posedge CLK) begin
    m = DEC_PFX_LONG ? DEC_PFX_B1[4:0] : 5'h01;
    e_on = !RST;
    e_v = DEC_VALID && !RST;
    e_inv = DEC_HAS_PFX && (!DEC_PFX_OK || DEC_MM_X87 || m == 5'h00
            || m > 5'h03);
    e_nd = DEC_HAS_PFX ? ~DEC_PFX_B2[6:3] : 4'h0;
    e_th = DEC_IMM[7:4];
    e_x4 = !DEC_HAS_PFX ? 4'h0 : DEC_PFX_LONG ?
           {~DEC_PFX_B1[7:5], DEC_PFX_B2[7]} : {~DEC_PFX_B2[7], 3'h0};
    if (!MODE64) begin
      e_nd[3] = 1'b0;
      e_th[3] = 1'b0;
      e_x4[3:1] = 3'h0;
    end
    e_pfx = DEC_HAS_PFX ? pp_tab[DEC_PFX_B2[1:0]] : 8'h00;
    e_esc = DEC_HAS_PFX ? m[1:0] : 2'h0;
    e_vl = DEC_HAS_PFX && DEC_PFX_B2[2];
    e_al = DEC_HAS_PFX ? DEC_MEM_OP && DEC_ALIGNED_OP : DEC_MEM_OP;
    e_4op = DEC_HAS_PFX && DEC_FOUR_OP;
    if (RST) begin
      mdl = '{default: '0};
    end
    e_rd = mdl[ix(RD_IDX)];
    if (WR_EN && !RST) begin
      hi = !WR_PREFIXED ? mdl[ix(WR_IDX)][255:128] :
           WR_VL256 ? WR_DATA[255:128] : 128'h0;
      mdl[ix(WR_IDX)] = {hi, WR_DATA[127:0]};
    end
    // random write port, read index and mode
    r = $random(seed);
    for (int i = 0; i < 8; i++) d[i*32 +: 32] = $random(seed);
    MODE64 <= r[0] || r[1];
    WR_EN <= r[2];
    WR_IDX <= r[6:3];
    WR_PREFIXED <= r[7];
    WR_VL256 <= r[8];
    WR_DATA <= d;
    RD_IDX <= r[12:9];
  end

  always @(negedge CLK) begin
    if (e_on) begin
      check(OUT_VALID, e_v);
      check(RD_WIDE, e_rd);
      check(RD_NARROW, e_rd[127:0]);
    end
    if (e_v) begin
      check(OUT_INVALID_OP, e_inv);
    end
    if (e_v && !e_inv) begin
      check(OUT_SRC_ND, e_nd);
      check({OUT_EXT_R, OUT_EXT_X, OUT_EXT_B, OUT_WIDE_OP}, e_x4);
      check(OUT_SIMD_PFX, e_pfx);
      check(OUT_ESC, e_esc);
      check(OUT_VL256, e_vl);
      check(OUT_ALIGN_REQ, e_al);
    end
    if (e_v && !e_inv && e_4op) begin
      check(OUT_SRC_THIRD, e_th);
    end
  end

  // hang guard well above the planned run length
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // write port, mode and expectations have the model process as sole driver
  initial begin
    RST = 1'b1;
    EN = 1'b0;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    EN <= 1'b1;
    repeat (1500) @(posedge CLK);
    // second reset in mid-run: registers and decode state must clear
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    repeat (1500) @(posedge CLK);
    give_verdict();
  end
endmodule // vsrc_top_bench
